//--- mlie_exec.sv
// execute stage for move, store, literal, idle, option and return instructions
`timescale 1ns/1ps
module mlie_exec (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  output logic instr_ready,
  output logic [4:0] file_raddr,
  input wire logic [7:0] file_rdata,
  output mlie_pkg::mlie_fwr_t file_wr,
  input wire logic [9:0] stack_top,
  output logic stack_pop,
  output mlie_pkg::mlie_pcld_t pc_load,
  output logic [7:0] working,
  output logic [7:0] option_reg,
  output logic zero_we,
  output logic zero_val,
  output logic unknown_instr
);
  // sequencer states: normal issue, then the flush cycle of a return
  typedef enum {MLIE_RUN, MLIE_RET2} mlie_state_t;

  // decoded operation of the word on the bus
  mlie_pkg::mlie_op_t op;

  // operand fields of the word
  logic dest_file;
  logic [7:0] literal;
  logic [4:0] file_addr;
  logic moved_is_zero;

  // handshake and one-hot execute strobes
  logic take;
  logic do_move;
  logic do_store;
  logic do_lit_load;
  logic do_option;
  logic do_lit_ret;
  logic do_other;

  // sequencer
  mlie_state_t state;
  mlie_state_t next_state;

  // registers kept in this block
  logic [7:0] next_working;
  logic [7:0] next_option_reg;

  // requests toward the register file, stack and program counter
  mlie_pkg::mlie_fwr_t next_file_wr;
  mlie_pkg::mlie_pcld_t next_pc_load;
  logic next_stack_pop;

  // status pulses
  logic next_zero_we;
  logic next_zero_val;
  logic next_unknown;

  // pure decode, no state: the word is only judged when taken
  mlie_decode u_dec (
    .instr(instr),
    .op(op)
  );

  // operands sit at fixed positions in every word of the group
  assign file_addr = instr[mlie_pkg::ADDR_W-1:0];
  assign dest_file = instr[mlie_pkg::DEST_BIT];
  assign literal = instr[mlie_pkg::LIT_LSB +: mlie_pkg::DATA_W];

  // register file read is asynchronous so the move completes in one cycle
  assign file_raddr = file_addr;
  // zero test of the value read this cycle; only a move uses it
  assign moved_is_zero = (file_rdata == 8'h00);

  // second cycle of a return flushes: no new word is taken
  assign instr_ready = (state == MLIE_RUN);
  assign take = instr_valid && instr_ready;

  // one strobe per operation except idle, all low unless a word is taken
  always_comb begin
    do_move = 1'h0;
    do_store = 1'h0;
    do_lit_load = 1'h0;
    do_option = 1'h0;
    do_lit_ret = 1'h0;
    do_other = 1'h0;
    if (take) begin
      case (op)
        mlie_pkg::MLIE_OP_FILE_MOVE: begin
          do_move = 1'h1;
        end
        mlie_pkg::MLIE_OP_STORE: begin
          do_store = 1'h1;
        end
        mlie_pkg::MLIE_OP_LIT_LOAD: begin
          do_lit_load = 1'h1;
        end
        mlie_pkg::MLIE_OP_OPTION: begin
          do_option = 1'h1;
        end
        mlie_pkg::MLIE_OP_LIT_RET: begin
          do_lit_ret = 1'h1;
        end
        mlie_pkg::MLIE_OP_IDLE: begin
          do_other = 1'h0;
        end
        default: begin
          do_other = 1'h1; // other groups execute elsewhere
        end
      endcase
    end
  end

  // sequencer: a return holds off the next word for one cycle
  always_comb begin
    next_state = state;
    case (state)
      MLIE_RUN: begin
        if (do_lit_ret) begin
          next_state = MLIE_RET2;
        end
      end
      MLIE_RET2: begin
        next_state = MLIE_RUN; // the waiting word stays on the bus
      end
      default: begin
        next_state = MLIE_RUN;
      end
    endcase
  end

  // sequencer register
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= MLIE_RUN;
    end else begin
      state <= next_state;
    end
  end

  // working and option; the strobes are one-hot so no two sources meet
  always_comb begin
    next_working = working;
    next_option_reg = option_reg;
    if (do_move && !dest_file) begin
      next_working = file_rdata;
    end
    if (do_lit_load || do_lit_ret) begin
      next_working = literal;
    end
    if (do_option) begin
      next_option_reg = working;
    end
  end

  // working and option registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      working <= mlie_pkg::WORK_RESET;
      option_reg <= mlie_pkg::OPTION_RESET;
    end else begin
      working <= next_working;
      option_reg <= next_option_reg;
    end
  end

  // requests are one-cycle pulses; the register file does the write
  always_comb begin
    next_file_wr = '0;
    next_pc_load = '0;
    next_stack_pop = 1'h0;
    if (do_move && dest_file) begin
      next_file_wr.en = 1'h1;
      next_file_wr.addr = file_addr;
      next_file_wr.data = file_rdata;
    end
    if (do_store) begin
      next_file_wr.en = 1'h1;
      next_file_wr.addr = file_addr;
      next_file_wr.data = working;
    end
    if (do_lit_ret) begin
      next_pc_load.en = 1'h1;
      next_pc_load.addr = stack_top;
      next_stack_pop = 1'h1;
    end
  end

  // request registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      file_wr <= '0;
      pc_load <= '0;
      stack_pop <= 1'h0;
    end else begin
      file_wr <= next_file_wr;
      pc_load <= next_pc_load;
      stack_pop <= next_stack_pop;
    end
  end

  // status pulses; the flag itself lives outside, so a store leaves it alone
  always_comb begin
    next_zero_we = 1'h0;
    next_zero_val = 1'h0;
    next_unknown = 1'h0;
    if (do_move) begin
      next_zero_we = 1'h1;
      next_zero_val = moved_is_zero;
    end
    if (do_other) begin
      next_unknown = 1'h1; // word left to the other groups
    end
  end

  // status registers
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      zero_we <= 1'h0;
      zero_val <= 1'h0;
      unknown_instr <= 1'h0;
    end else begin
      zero_we <= next_zero_we;
      zero_val <= next_zero_val;
      unknown_instr <= next_unknown;
    end
  end
endmodule : mlie_exec

//--- mlie_pkg.sv
// constants and carrier types for the move and literal instruction executor
package mlie_pkg;
  localparam int DATA_W = 8;
  localparam int INSTR_W = 12;
  localparam int ADDR_W = 5;
  localparam int PC_W = 10;
  localparam int DEST_BIT = 5;
  localparam int LIT_LSB = 0;
  localparam logic [11:0] FILE_MOVE_MASK = 12'hfc0;
  localparam logic [11:0] FILE_MOVE_PAT = 12'h200;
  localparam logic [11:0] STORE_MASK = 12'hfe0;
  localparam logic [11:0] STORE_PAT = 12'h020;
  localparam logic [11:0] LIT_LOAD_MASK = 12'hf00;
  localparam logic [11:0] LIT_LOAD_PAT = 12'hc00;
  localparam logic [11:0] LIT_RET_MASK = 12'hf00;
  localparam logic [11:0] LIT_RET_PAT = 12'h800;
  localparam logic [11:0] IDLE_PAT = 12'h000;
  localparam logic [11:0] OPTION_PAT = 12'h002;
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam int RET_CYCLES = 2;

  typedef enum logic [2:0] {
    MLIE_OP_NONE, MLIE_OP_FILE_MOVE, MLIE_OP_STORE, MLIE_OP_LIT_LOAD,
    MLIE_OP_IDLE, MLIE_OP_OPTION, MLIE_OP_LIT_RET
  } mlie_op_t;

  // register file write request
  typedef struct packed {
    logic en;
    logic [4:0] addr;
    logic [7:0] data;
  } mlie_fwr_t;

  // program counter load request
  typedef struct packed {
    logic en;
    logic [9:0] addr;
  } mlie_pcld_t;
endpackage : mlie_pkg

//--- mlie_decode.sv
// combinational decoder of one instruction word
`timescale 1ns/1ps
module mlie_decode (
  input wire logic [11:0] instr,
  output mlie_pkg::mlie_op_t op
);
  // patterns are disjoint, order only matters for readability
  always_comb begin
    if ((instr & mlie_pkg::FILE_MOVE_MASK) == mlie_pkg::FILE_MOVE_PAT) begin
      op = mlie_pkg::MLIE_OP_FILE_MOVE;
    end else if ((instr & mlie_pkg::STORE_MASK) == mlie_pkg::STORE_PAT) begin
      op = mlie_pkg::MLIE_OP_STORE;
    end else if ((instr & mlie_pkg::LIT_LOAD_MASK) == mlie_pkg::LIT_LOAD_PAT) begin
      op = mlie_pkg::MLIE_OP_LIT_LOAD;
    end else if ((instr & mlie_pkg::LIT_RET_MASK) == mlie_pkg::LIT_RET_PAT) begin
      op = mlie_pkg::MLIE_OP_LIT_RET;
    end else if (instr == mlie_pkg::IDLE_PAT) begin
      op = mlie_pkg::MLIE_OP_IDLE;
    end else if (instr == mlie_pkg::OPTION_PAT) begin
      op = mlie_pkg::MLIE_OP_OPTION;
    end else begin
      op = mlie_pkg::MLIE_OP_NONE;
    end
  end
endmodule : mlie_decode

//--- mlie_chk.sv
// port checker of the move and literal executor
`timescale 1ns/1ps
module mlie_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic instr_valid,
  input wire logic [11:0] instr,
  input wire logic instr_ready,
  input wire logic [7:0] file_rdata,
  input wire mlie_pkg::mlie_fwr_t file_wr,
  input wire logic stack_pop,
  input wire logic [7:0] working,
  input wire logic zero_we,
  input wire logic zero_val
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // taken words sorted by opcode bits
  wire logic tk = instr_valid && instr_ready;
  wire logic mv = tk && instr[11:6] == 6'h08;
  wire logic st = tk && instr[11:5] == 7'h01;
  wire logic ll = tk && instr[11:8] == 4'hc;
  wire logic rt = tk && instr[11:8] == 4'h8;
  sequence s_ret_busy;
    stack_pop && !instr_ready;
  endsequence
  a_move_dest: assert property (mv |=> $past(instr[5])
    ? (file_wr.en && file_wr.data == $past(file_rdata))
    : (!file_wr.en && working == $past(file_rdata))) else $error("move result misplaced");
  a_move_zero: assert property (mv |=> zero_we && zero_val == ($past(file_rdata) == 8'h00))
    else $error("move zero flag wrong");
  a_store_copy: assert property (st |=> file_wr.en && file_wr.data == $past(working) && !zero_we
    && file_wr.addr == $past(instr[4:0])) else $error("store wrong");
  a_lit_load: assert property (ll |=> working == $past(instr[7:0]) && !zero_we)
    else $error("literal load wrong");
  a_ret_steps: assert property (rt |=> s_ret_busy ##1 instr_ready)
    else $error("return timing wrong");
endmodule : mlie_chk

//--- mlie_pmem.sv
// program memory model handing out instruction words
`timescale 1ns/1ps
module mlie_pmem (
  input wire logic clk,
  input wire logic go,
  input wire logic [11:0] word,
  input wire logic instr_ready,
  output logic instr_valid = 1'h0,
  output logic [11:0] instr = 12'h000
);
  // word held until taken; bus then toggles so no stale word looks real
  always @(posedge clk) begin
    instr_valid <= go || (instr_valid && !instr_ready);
    instr <= go ? word : (instr_valid && !instr_ready) ? instr : ~instr;
  end
endmodule : mlie_pmem

//--- tb_top.sv
// self-checking bench for the move and literal executor
`timescale 1ns/1ps
module tb_top;
  logic clk = 1'h0;
  logic nrst = 1'h0;
  logic go = 1'h0;
  logic [11:0] word = 12'h000;
  logic instr_valid, instr_ready, stack_pop, zero_we, zero_val, unknown_instr;
  logic [11:0] instr;
  logic [4:0] file_raddr;
  logic [7:0] working, option_reg;
  mlie_pkg::mlie_fwr_t file_wr;
  mlie_pkg::mlie_pcld_t pc_load;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  // register file reads back its address pattern, zero at address 0
  wire logic [7:0] file_rdata = {file_raddr, 3'h0};
  wire logic [9:0] stack_top = 10'h2a5;
  initial begin
    forever #12.5 clk = ~clk;
  end
  mlie_pmem pm (
    .clk(clk),
    .go(go),
    .word(word),
    .instr_ready(instr_ready),
    .instr_valid(instr_valid),
    .instr(instr)
  );
  mlie_exec dut (
    .clk(clk),
    .nrst(nrst),
    .instr_valid(instr_valid),
    .instr(instr),
    .instr_ready(instr_ready),
    .file_raddr(file_raddr),
    .file_rdata(file_rdata),
    .file_wr(file_wr),
    .stack_top(stack_top),
    .stack_pop(stack_pop),
    .pc_load(pc_load),
    .working(working),
    .option_reg(option_reg),
    .zero_we(zero_we),
    .zero_val(zero_val),
    .unknown_instr(unknown_instr)
  );
  task chk(input logic [23:0] got, input logic [23:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : chk
  // one word through the memory model, returns once its effects land
  task run(input logic [11:0] w);
    @(posedge clk);
    #2 go = 1'h1;
    word = w;
    @(posedge clk);
    #2 go = 1'h0;
    @(posedge clk);
    #2;
  endtask : run
  task t_literal;
    chk({working, option_reg}, 16'h00ff);
    run(12'hc5a);
    chk(working, 8'h5a);
    run(12'h033);
    chk({file_wr, zero_we}, {1'h1, 5'h13, 8'h5a, 1'h0});
    run(12'h002);
    chk(option_reg, 8'h5a);
  endtask : t_literal
  task t_move;
    run(12'h213);
    chk({working, zero_we, zero_val, file_wr.en}, {8'h98, 3'h4});
    run(12'h220);
    chk({file_wr, zero_val, working}, {1'h1, 5'h00, 8'h00, 1'h1, 8'h98});
    run(12'h227);
    chk({file_wr, zero_we, zero_val, working}, {1'h1, 5'h07, 8'h38, 2'h2, 8'h98});
    run(12'h200);
    chk({working, zero_we, zero_val, file_wr.en}, {8'h00, 3'h6});
  endtask : t_move
  task t_return;
    run(12'h8c3);
    chk({working, stack_pop, pc_load, instr_ready}, {8'hc3, 2'h3, 10'h2a5, 1'h0});
    @(posedge clk);
    #2;
    chk({instr_ready, stack_pop, pc_load.en}, 3'h4);
    run(12'h000);
    chk({working, file_wr.en, zero_we, pc_load.en, instr_ready}, {8'hc3, 4'h1});
  endtask : t_return
  // a word of another group must leave working and the write, zero_we, stack_pop and pc_load strobes alone except the unknown_instr pulse
  task t_other;
    run(12'h3c5);
    chk({working, unknown_instr, file_wr.en, zero_we, stack_pop, pc_load.en}, {8'hc3, 5'h10});
    @(posedge clk);
    #2;
    chk({unknown_instr, instr_ready}, 2'h1);
  endtask : t_other
  // reset in the flush cycle of a return, then a word right after release
  task t_reset;
    run(12'h8c3);
    nrst = 1'h0;
    #1;
    chk({working, option_reg, file_wr.en, stack_pop, pc_load.en, instr_ready}, {8'h00, 8'hff, 4'h1});
    repeat (2) @(posedge clk);
    #2 nrst = 1'h1;
    run(12'hc11);
    chk(working, 8'h11);
  endtask : t_reset
  task give_verdict;
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : give_verdict
  // hang guard, far above the forty or so cycles needed
  always @(posedge clk) begin
    cycles++;
    if (cycles == 500) begin
      bad_count++;
      give_verdict();
    end
  end
  initial begin
    repeat (2) @(posedge clk);
    #2 nrst = 1'h1;
    t_literal();
    t_move();
    t_return();
    t_other();
    t_reset();
    give_verdict();
  end
endmodule : tb_top
// checker sees only the executor's ports
bind mlie_exec mlie_chk chk_i (
  .clk(clk),
  .nrst(nrst),
  .instr_valid(instr_valid),
  .instr(instr),
  .instr_ready(instr_ready),
  .file_rdata(file_rdata),
  .file_wr(file_wr),
  .stack_pop(stack_pop),
  .working(working),
  .zero_we(zero_we),
  .zero_val(zero_val)
);
